// file: spf_top.sv
// holds the shared pin function select top for port m, l, k and j pins
// assumes peripheral controls arrive on i_clk and pins are asynchronous
`timescale 1ns/10ps

// Function
// - tx pin driven by channel 7 when enabled
// - port m bit is gpio only when unused
// - clock pin to serial in ext/out modes
// - i2c pins open drain to i2c logic when enabled in standard mode
// - i2c disabled: pins are open-drain gpio
// - rx pin level feeds channel 7 receiver
// - sixteen interrupt pins feed detection when enabled
// - freerun clock pin used when selected
// - adc trigger pin passed when selected
// - three counter pins feed counter when enabled
// - trigger pins feed pulse generators 3-5
module spf_top (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire spf_pkg::spf_serial_s i_serial,
	input wire spf_pkg::spf_i2c_s i_i2c,
	input wire logic i_counter1_enable,
	input wire logic [spf_pkg::NUM_TRIG-1:0] i_pulse_gen_trig_enable,
	input wire logic [spf_pkg::NUM_IRQ-1:0] i_ext_irq_enable,
	input wire logic i_freerun_ext_clock_sel,
	input wire logic i_adc_ext_trigger_sel,
	input wire logic [spf_pkg::NUM_PORT_M-1:0] i_port_m_out,
	input wire logic [spf_pkg::NUM_PORT_M-1:0] i_port_m_oe,
	input wire logic [1:0] i_port_l_out,
	input wire logic [1:0] i_port_l_oe,
	input wire logic [spf_pkg::NUM_PORT_K-1:0] i_port_k_out,
	input wire logic [spf_pkg::NUM_PORT_K-1:0] i_port_k_oe,
	input wire logic [spf_pkg::NUM_PORT_J-1:0] i_port_j_out,
	input wire logic [spf_pkg::NUM_PORT_J-1:0] i_port_j_oe,
	input wire logic [spf_pkg::NUM_PORT_M-1:0] i_port_m_pin,
	input wire logic [1:0] i_port_l_pin,
	input wire logic [spf_pkg::NUM_PORT_K-1:0] i_port_k_pin,
	input wire logic [spf_pkg::NUM_PORT_J-1:0] i_port_j_pin,
	output logic [spf_pkg::NUM_PORT_M-1:0] o_port_m_pin,
	output logic [spf_pkg::NUM_PORT_M-1:0] o_port_m_pin_oe,
	output logic [1:0] o_port_l_pin,
	output logic [1:0] o_port_l_pin_oe,
	output logic [spf_pkg::NUM_PORT_K-1:0] o_port_k_pin,
	output logic [spf_pkg::NUM_PORT_K-1:0] o_port_k_pin_oe,
	output logic [spf_pkg::NUM_PORT_J-1:0] o_port_j_pin,
	output logic [spf_pkg::NUM_PORT_J-1:0] o_port_j_pin_oe,
	output logic [spf_pkg::NUM_PORT_M-1:0] o_port_m_in,
	output logic [1:0] o_port_l_in,
	output logic [spf_pkg::NUM_PORT_K-1:0] o_port_k_in,
	output logic [spf_pkg::NUM_PORT_J-1:0] o_port_j_in,
	output spf_pkg::spf_periph_in_s o_periph,
	output logic [spf_pkg::NUM_IRQ-1:0] o_ext_irq,
	output logic [spf_pkg::NUM_PORT_M-1:0] o_port_m_gpio
);
	import spf_pkg::*;

	//----------------------------------------
	// reset release
	//----------------------------------------
	logic rst_meta;
	logic rst_n;
	logic next_rst_meta;
	logic next_rst_n;

	// release ripples through two flops so no flop sees it near an edge
	always_comb begin
		next_rst_meta = 1'b1;
		next_rst_n = rst_meta;
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= next_rst_meta;
			rst_n <= next_rst_n;
		end
	end

	//----------------------------------------
	// pin input synchronisers
	//----------------------------------------
	logic [NUM_PORT_M-1:0] m_sync;
	logic [1:0] l_sync;
	logic [NUM_PORT_K-1:0] k_sync;
	logic [NUM_PORT_J-1:0] j_sync;

	spf_sync #(.WIDTH(NUM_PORT_M)) u_sync_m (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_async(i_port_m_pin),
		.o_sync(m_sync)
	);
	spf_sync #(.WIDTH(2)) u_sync_l (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_async(i_port_l_pin),
		.o_sync(l_sync)
	);
	spf_sync #(.WIDTH(NUM_PORT_K)) u_sync_k (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_async(i_port_k_pin),
		.o_sync(k_sync)
	);
	spf_sync #(.WIDTH(NUM_PORT_J)) u_sync_j (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_async(i_port_j_pin),
		.o_sync(j_sync)
	);

	//----------------------------------------
	// function selection
	//----------------------------------------
	logic i2c_on;
	logic [NUM_PORT_M-1:0] m_in_use;
	logic [NUM_PORT_M-1:0] m_periph_sel;
	logic [NUM_PORT_M-1:0] m_periph_out;
	logic [NUM_PORT_M-1:0] m_periph_oe;
	logic [1:0] l_periph_out;
	logic [1:0] l_periph_oe;
	logic sck_in_use;

	// a port m bit is taken when any of its three functions wants it
	function automatic logic pin_taken(input logic serial_use, input logic counter_use,
			input logic trig_use);
		pin_taken = serial_use | counter_use | trig_use;
	endfunction : pin_taken

	always_comb begin
		i2c_on = i_i2c.enable & i_i2c.standard_mode;
		sck_in_use = i_serial.ext_clock_mode | i_serial.clock_out_enable;
		m_in_use[M_RX] = pin_taken(i_serial.rx_active, i_counter1_enable,
			i_pulse_gen_trig_enable[0]);
		m_in_use[M_TX] = pin_taken(i_serial.tx_enable, i_counter1_enable,
			i_pulse_gen_trig_enable[1]);
		m_in_use[M_SCK] = pin_taken(sck_in_use, i_counter1_enable,
			i_pulse_gen_trig_enable[2]);
		// only tx and clock-out drive; input functions leave port driver as set
		m_periph_sel = '0;
		m_periph_sel[M_TX] = i_serial.tx_enable;
		m_periph_sel[M_SCK] = i_serial.clock_out_enable;
		m_periph_out = '0;
		m_periph_out[M_TX] = i_serial.tx_data;
		m_periph_out[M_SCK] = i_serial.clock_out;
		m_periph_oe = m_periph_sel;
		l_periph_out = 2'h0;
		l_periph_oe = {i_i2c.scl_drive_low, i_i2c.sda_drive_low};
	end

	//----------------------------------------
	// output pads
	//----------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_PORT_M; g++) begin : g_pad_m
			spf_pad u_pad (
				.i_clk(i_clk),
				.i_rst_n(rst_n),
				.i_periph_sel(m_periph_sel[g]),
				.i_periph_out(m_periph_out[g]),
				.i_periph_oe(m_periph_oe[g]),
				.i_port_out(i_port_m_out[g]),
				.i_port_oe(i_port_m_oe[g]),
				.i_open_drain(1'b0),
				.o_pin_out(o_port_m_pin[g]),
				.o_pin_oe(o_port_m_pin_oe[g])
			);
		end
		for (g = 0; g < 2; g++) begin : g_pad_l
			spf_pad u_pad (
				.i_clk(i_clk),
				.i_rst_n(rst_n),
				.i_periph_sel(i2c_on),
				.i_periph_out(l_periph_out[g]),
				.i_periph_oe(l_periph_oe[g]),
				.i_port_out(i_port_l_out[g]),
				.i_port_oe(i_port_l_oe[g]),
				.i_open_drain(1'b1),
				.o_pin_out(o_port_l_pin[g]),
				.o_pin_oe(o_port_l_pin_oe[g])
			);
		end
		for (g = 0; g < NUM_PORT_K; g++) begin : g_pad_k
			spf_pad u_pad (
				.i_clk(i_clk),
				.i_rst_n(rst_n),
				.i_periph_sel(1'b0),
				.i_periph_out(1'b0),
				.i_periph_oe(1'b0),
				.i_port_out(i_port_k_out[g]),
				.i_port_oe(i_port_k_oe[g]),
				.i_open_drain(1'b0),
				.o_pin_out(o_port_k_pin[g]),
				.o_pin_oe(o_port_k_pin_oe[g])
			);
		end
		for (g = 0; g < NUM_PORT_J; g++) begin : g_pad_j
			spf_pad u_pad (
				.i_clk(i_clk),
				.i_rst_n(rst_n),
				.i_periph_sel(1'b0),
				.i_periph_out(1'b0),
				.i_periph_oe(1'b0),
				.i_port_out(i_port_j_out[g]),
				.i_port_oe(i_port_j_oe[g]),
				.i_open_drain(1'b0),
				.o_pin_out(o_port_j_pin[g]),
				.o_pin_oe(o_port_j_pin_oe[g])
			);
		end
	endgenerate

	//----------------------------------------
	// inputs toward peripherals and port registers
	//----------------------------------------
	spf_periph_in_s periph;
	spf_periph_in_s next_periph;
	logic [NUM_IRQ-1:0] irq;
	logic [NUM_IRQ-1:0] next_irq;
	logic [NUM_IRQ-1:0] irq_pins;
	logic [NUM_PORT_M-1:0] m_in;
	logic [1:0] l_in;
	logic [NUM_PORT_K-1:0] k_in;
	logic [NUM_PORT_J-1:0] j_in;
	logic [NUM_PORT_M-1:0] m_gpio;
	logic [NUM_PORT_M-1:0] next_m_gpio;

	always_comb begin
		irq_pins = {j_sync, k_sync};
		next_irq = irq_pins & i_ext_irq_enable;
		next_periph = '0;
		next_periph.serial_rx = m_sync[M_RX] & i_serial.rx_active;
		next_periph.serial_clock_in = m_sync[M_SCK] & i_serial.ext_clock_mode;
		next_periph.counter1_phase_a = m_sync[M_RX] & i_counter1_enable;
		next_periph.counter1_phase_b = m_sync[M_TX] & i_counter1_enable;
		next_periph.counter1_zero_input = m_sync[M_SCK] & i_counter1_enable;
		next_periph.pulse_gen_trigger = m_sync & i_pulse_gen_trig_enable;
		// released bus lines read high
		next_periph.i2c_sda_in = i2c_on ? l_sync[0] : 1'b1;
		next_periph.i2c_scl_in = i2c_on ? l_sync[1] : 1'b1;
		next_periph.freerun_clock = k_sync[IDX_K_FREERUN] & i_freerun_ext_clock_sel;
		next_periph.adc_trigger = k_sync[IDX_K_ADC] & i_adc_ext_trigger_sel;
		next_m_gpio = ~m_in_use;
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			periph <= '0;
			irq <= '0;
			m_gpio <= '1;
		end else begin
			periph <= next_periph;
			irq <= next_irq;
			m_gpio <= next_m_gpio;
		end
	end

	//----------------------------------------
	// port data read path
	//----------------------------------------
	logic [NUM_PORT_M-1:0] next_m_in;
	logic [1:0] next_l_in;
	logic [NUM_PORT_K-1:0] next_k_in;
	logic [NUM_PORT_J-1:0] next_j_in;

	// port reads see the pin whatever function holds it
	always_comb begin
		next_m_in = m_sync;
		next_l_in = l_sync;
		next_k_in = k_sync;
		next_j_in = j_sync;
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			m_in <= '0;
			l_in <= '0;
			k_in <= '0;
			j_in <= '0;
		end else begin
			m_in <= next_m_in;
			l_in <= next_l_in;
			k_in <= next_k_in;
			j_in <= next_j_in;
		end
	end

	assign o_periph = periph;
	assign o_ext_irq = irq;
	assign o_port_m_gpio = m_gpio;
	assign o_port_m_in = m_in;
	assign o_port_l_in = l_in;
	assign o_port_k_in = k_in;
	assign o_port_j_in = j_in;
endmodule : spf_top

// file: spf_pkg.sv
// holds shared constants and carrier structs for the shared pin function select block
// assumes a single system clock and no register bus
package spf_pkg;
	localparam int NUM_IRQ = 16;
	localparam int NUM_PORT_K = 8;
	localparam int NUM_PORT_J = 8;
	localparam int NUM_PORT_M = 3;
	localparam int NUM_TRIG = 3;
	localparam int IDX_K_FREERUN = 6;
	localparam int IDX_K_ADC = 7;
	localparam int IRQ_K_BASE = 0;
	localparam int IRQ_J_BASE = 8;
	localparam int M_RX = 0;
	localparam int M_TX = 1;
	localparam int M_SCK = 2;
	localparam logic RST_PIN_OUT = 1'b0;
	localparam logic RST_PIN_OE = 1'b0;
	localparam logic RST_SYNC = 1'b0;

	// serial channel 7 controls and data from the serial logic
	typedef struct packed {
		logic rx_active;
		logic tx_enable;
		logic ext_clock_mode;
		logic clock_out_enable;
		logic tx_data;
		logic clock_out;
	} spf_serial_s;

	// i2c unit controls from the i2c logic
	typedef struct packed {
		logic enable;
		logic standard_mode;
		logic sda_drive_low;
		logic scl_drive_low;
	} spf_i2c_s;

	// peripheral-side inputs after routing
	typedef struct packed {
		logic serial_rx;
		logic serial_clock_in;
		logic counter1_phase_a;
		logic counter1_phase_b;
		logic counter1_zero_input;
		logic [NUM_TRIG-1:0] pulse_gen_trigger;
		logic i2c_sda_in;
		logic i2c_scl_in;
		logic freerun_clock;
		logic adc_trigger;
	} spf_periph_in_s;
endpackage : spf_pkg

// file: spf_sync.sv
// holds a two-flop synchroniser array for pin inputs
// assumes an active-low asynchronous reset already released synchronously
`timescale 1ns/10ps
module spf_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	import spf_pkg::*;
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_stage2;

	always_comb begin
		next_stage1 = i_async;
		next_stage2 = stage1;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage1 <= {WIDTH{RST_SYNC}};
			stage2 <= {WIDTH{RST_SYNC}};
		end else begin
			stage1 <= next_stage1;
			stage2 <= next_stage2;
		end
	end

	assign o_sync = stage2;
endmodule : spf_sync

// file: spf_pad.sv
// holds one shared pad cell: port or peripheral output select with registered drive
// assumes the select and data inputs are on the system clock
`timescale 1ns/10ps
module spf_pad (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_periph_sel,
	input wire logic i_periph_out,
	input wire logic i_periph_oe,
	input wire logic i_port_out,
	input wire logic i_port_oe,
	input wire logic i_open_drain,
	output logic o_pin_out,
	output logic o_pin_oe
);
	import spf_pkg::*;
	logic pin_out;
	logic pin_oe;
	logic next_pin_out;
	logic next_pin_oe;
	logic sel_out;
	logic sel_oe;

	always_comb begin
		sel_out = i_periph_sel ? i_periph_out : i_port_out;
		sel_oe = i_periph_sel ? i_periph_oe : i_port_oe;
		// open drain drives only low
		if (i_open_drain) begin
			next_pin_out = 1'b0;
			next_pin_oe = sel_oe & ~sel_out;
		end else begin
			next_pin_out = sel_out;
			next_pin_oe = sel_oe;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_out <= RST_PIN_OUT;
			pin_oe <= RST_PIN_OE;
		end else begin
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
		end
	end

	assign o_pin_out = pin_out;
	assign o_pin_oe = pin_oe;
endmodule : spf_pad

// file: spf_board.sv
// holds a board model for one group of shared pads
// assumes device drive on i_clk; idle plain lines toggle, pulled lines float high
`timescale 1ns/10ps
module spf_board #(
	parameter int W = 1,
	parameter bit PULL = 0
) (
	input wire logic i_clk,
	input wire logic [W-1:0] i_out,
	input wire logic [W-1:0] i_oe,
	input wire logic [W-1:0] i_drv,
	input wire logic [W-1:0] i_drv_en,
	output logic [W-1:0] o_level
);
	logic [W-1:0] last = '0;
	always @(posedge i_clk) begin
		last <= o_level;
	end
	always_comb begin
		for (int b = 0; b < W; b++) begin
			if (PULL)
				o_level[b] = !(i_oe[b] || (i_drv_en[b] && !i_drv[b]));
			else if (i_oe[b])
				o_level[b] = i_out[b];
			else
				o_level[b] = i_drv_en[b] ? i_drv[b] : !last[b];
		end
	end
endmodule : spf_board

// file: spf_top_asserts.sv
// holds port-level assertions for spf_top
// assumes outputs follow inputs from the third edge after reset release
`timescale 1ns/10ps
module spf_top_asserts (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire spf_pkg::spf_serial_s i_serial,
	input wire spf_pkg::spf_i2c_s i_i2c,
	input wire logic i_counter1_enable,
	input wire logic [spf_pkg::NUM_TRIG-1:0] i_pulse_gen_trig_enable,
	input wire logic [spf_pkg::NUM_IRQ-1:0] i_ext_irq_enable,
	input wire logic i_freerun_ext_clock_sel,
	input wire logic i_adc_ext_trigger_sel,
	input wire logic [1:0] i_port_l_out,
	input wire logic [1:0] i_port_l_oe,
	input wire logic [spf_pkg::NUM_PORT_M-1:0] o_port_m_pin,
	input wire logic [spf_pkg::NUM_PORT_M-1:0] o_port_m_pin_oe,
	input wire logic [1:0] o_port_l_pin_oe,
	input wire logic [spf_pkg::NUM_PORT_K-1:0] o_port_k_pin_oe,
	input wire logic [spf_pkg::NUM_PORT_M-1:0] o_port_m_in,
	input wire logic [spf_pkg::NUM_PORT_K-1:0] o_port_k_in,
	input wire logic [spf_pkg::NUM_PORT_J-1:0] o_port_j_in,
	input wire spf_pkg::spf_periph_in_s o_periph,
	input wire logic [spf_pkg::NUM_IRQ-1:0] o_ext_irq,
	input wire logic [spf_pkg::NUM_PORT_M-1:0] o_port_m_gpio
);
	import spf_pkg::*;
	// edges since reset release, saturating at three
	logic [1:0] up;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			up <= 2'h0;
		else if (up != 2'h3)
			up <= up + 2'h1;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	property p_tx;
		up == 2'h3 && $past(i_serial.tx_enable) |->
			o_port_m_pin[1] == $past(i_serial.tx_data) && o_port_m_pin_oe[1];
	endproperty
	a_tx: assert property (p_tx) else $error("tx pad mismatch");
	property p_gpio;
		up == 2'h3 && $past(i_counter1_enable) |-> o_port_m_gpio == 3'h0;
	endproperty
	a_gpio: assert property (p_gpio) else $error("gpio flag mismatch");
	property p_clk;
		up == 2'h3 && $past(i_serial.clock_out_enable) |->
			o_port_m_pin[2] == $past(i_serial.clock_out) && o_port_m_pin_oe[2];
	endproperty
	a_clk: assert property (p_clk) else $error("clock pad mismatch");
	property p_i2c;
		up == 2'h3 && $past(i_i2c.enable) && $past(i_i2c.standard_mode) |->
			o_port_l_pin_oe == {$past(i_i2c.scl_drive_low), $past(i_i2c.sda_drive_low)};
	endproperty
	a_i2c: assert property (p_i2c) else $error("i2c drive mismatch");
	property p_lgpio;
		up == 2'h3 && !$past(i_i2c.enable) |->
			o_port_l_pin_oe == ($past(i_port_l_oe) & ~$past(i_port_l_out));
	endproperty
	a_lgpio: assert property (p_lgpio) else $error("open drain port mismatch");
	property p_rx;
		up == 2'h3 |-> o_periph.serial_rx == (o_port_m_in[0] & $past(i_serial.rx_active));
	endproperty
	a_rx: assert property (p_rx) else $error("rx route mismatch");
	property p_irq;
		up == 2'h3 |-> o_ext_irq == ({o_port_j_in, o_port_k_in} & $past(i_ext_irq_enable));
	endproperty
	a_irq: assert property (p_irq) else $error("irq route mismatch");
	property p_freerun_ext_clock_pin;
		up == 2'h3 |->
			o_periph.freerun_clock == (o_port_k_in[6] & $past(i_freerun_ext_clock_sel));
	endproperty
	a_freerun_ext_clock_pin: assert property (p_freerun_ext_clock_pin) else $error("timer clock mismatch");
	property p_adc;
		up == 2'h3 |->
			o_periph.adc_trigger == (o_port_k_in[IDX_K_ADC] & $past(i_adc_ext_trigger_sel));
	endproperty
	a_adc: assert property (p_adc) else $error("adc trigger mismatch");
	property p_cnt;
		up == 2'h3 |-> {o_periph.counter1_zero_input, o_periph.counter1_phase_b,
			o_periph.counter1_phase_a} == (o_port_m_in & {3{$past(i_counter1_enable)}});
	endproperty
	a_cnt: assert property (p_cnt) else $error("counter route mismatch");
	property p_trig;
		up == 2'h3 |->
			o_periph.pulse_gen_trigger == (o_port_m_in & $past(i_pulse_gen_trig_enable));
	endproperty
	a_trig: assert property (p_trig) else $error("trigger route mismatch");
	property p_rst;
		up != 2'h3 |-> o_port_m_pin_oe == 3'h0 && o_port_k_pin_oe == 8'h0 && &o_port_m_gpio;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state mismatch");
	c_tx: cover property (o_port_m_pin_oe[1] && o_port_m_pin[1]);
	c_i2c: cover property (i_i2c.enable && o_port_l_pin_oe[0]);
	c_irq: cover property (o_ext_irq != 16'h0);
endmodule : spf_top_asserts
bind spf_top spf_top_asserts u_spf_top_asserts (.*);

// file: testbench.sv
// holds the self-checking bench for spf_top
// assumes board models resolve pad levels; inputs change on falling edges
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
	import spf_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	spf_serial_s ser = '0;
	spf_i2c_s i2c = '0;
	logic cen = 1'b0, fsel = 1'b0, asel = 1'b0;
	logic [2:0] ten = '0, mo = '0, moe = '0, mbv = '0, mbe = '0;
	logic [1:0] lo = '0, loe = '0, lbv = '0, lbe = '0;
	logic [7:0] ko = '0, koe = '0, kbv = '0, kbe = '0, jo = '0, joe = '0, jbv = '0, jbe = '0;
	logic [15:0] ien = '0, irq;
	logic [2:0] mp, mpe, ml, mi, mg;
	logic [1:0] lp, lpe, ll, li;
	logic [7:0] kp, kpe, kl, ki, jp, jpe, jl, ji;
	spf_periph_in_s pr;
	int num_errors = 0;
	int num_checks = 0;
	always #12.5 i_clk = ~i_clk;
	spf_board #(.W(3), .PULL(0)) u_spf_board_m (.i_clk(i_clk), .i_out(mp), .i_oe(mpe),
		.i_drv(mbv), .i_drv_en(mbe), .o_level(ml));
	spf_board #(.W(2), .PULL(1)) u_spf_board_l (.i_clk(i_clk), .i_out(lp), .i_oe(lpe),
		.i_drv(lbv), .i_drv_en(lbe), .o_level(ll));
	spf_board #(.W(8), .PULL(0)) u_spf_board_k (.i_clk(i_clk), .i_out(kp), .i_oe(kpe),
		.i_drv(kbv), .i_drv_en(kbe), .o_level(kl));
	spf_board #(.W(8), .PULL(0)) u_spf_board_j (.i_clk(i_clk), .i_out(jp), .i_oe(jpe),
		.i_drv(jbv), .i_drv_en(jbe), .o_level(jl));
	spf_top u_spf_top (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_serial(ser), .i_i2c(i2c),
		.i_counter1_enable(cen), .i_pulse_gen_trig_enable(ten), .i_ext_irq_enable(ien),
		.i_freerun_ext_clock_sel(fsel), .i_adc_ext_trigger_sel(asel), .i_port_m_out(mo),
		.i_port_m_oe(moe), .i_port_l_out(lo), .i_port_l_oe(loe), .i_port_k_out(ko),
		.i_port_k_oe(koe), .i_port_j_out(jo), .i_port_j_oe(joe), .i_port_m_pin(ml),
		.i_port_l_pin(ll), .i_port_k_pin(kl), .i_port_j_pin(jl), .o_port_m_pin(mp),
		.o_port_m_pin_oe(mpe), .o_port_l_pin(lp), .o_port_l_pin_oe(lpe), .o_port_k_pin(kp),
		.o_port_k_pin_oe(kpe), .o_port_j_pin(jp), .o_port_j_pin_oe(jpe), .o_port_m_in(mi),
		.o_port_l_in(li), .o_port_k_in(ki), .o_port_j_in(ji), .o_periph(pr), .o_ext_irq(irq),
		.o_port_m_gpio(mg));
	task settle(input int n);
		repeat (n) @(negedge i_clk);
	endtask : settle
	task report_and_stop;
		if (num_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	task t_reset;
		`CHK({mpe, lpe, kpe, jpe}, 21'h0)
		`CHK(mg, 3'h7)
	endtask : t_reset
	task t_tx;
		moe = 3'h2;
		ser.tx_enable = 1'b1;
		ser.tx_data = 1'b1;
		settle(2);
		`CHK({mp[1], mpe[1], mg[1]}, 3'h6)
		ser.tx_data = 1'b0;
		settle(2);
		`CHK(mp[1], 1'b0)
		ser.tx_enable = 1'b0;
		mo = 3'h2;
		settle(2);
		`CHK({mp[1], mpe[1], mg}, 5'h1f)
		moe = 3'h0;
	endtask : t_tx
	task t_clk;
		ser.clock_out_enable = 1'b1;
		ser.clock_out = 1'b1;
		settle(2);
		`CHK({mp[2], mpe[2]}, 2'h3)
		ser.clock_out_enable = 1'b0;
		ser.ext_clock_mode = 1'b1;
		{mbe, mbv} = 6'h24;
		settle(4);
		`CHK({pr.serial_clock_in, mpe[2]}, 2'h2)
		ser.ext_clock_mode = 1'b0;
		settle(2);
		`CHK(pr.serial_clock_in, 1'b0)
	endtask : t_clk
	task t_i2c;
		i2c = 4'he;
		settle(4);
		`CHK({lpe, pr.i2c_scl_in, pr.i2c_sda_in}, 4'h6)
		i2c.sda_drive_low = 1'b0;
		{lbe, lbv} = 4'h8;
		settle(4);
		`CHK({lpe, pr.i2c_scl_in, pr.i2c_sda_in}, 4'h1)
		i2c.scl_drive_low = 1'b1;
		{lbe, lbv} = 4'hf;
		settle(4);
		`CHK({lpe, pr.i2c_scl_in, pr.i2c_sda_in}, 4'h9)
		i2c = '0;
		{lbe, lo, loe} = 6'h0b;
		settle(4);
		`CHK({lpe, lp, li}, 6'h12)
		loe = 2'h0;
	endtask : t_i2c
	task t_ins;
		// port drivers stay off while the pins serve as inputs
		{mbe, mbv} = 6'h39;
		ser.rx_active = 1'b1;
		settle(4);
		`CHK({pr.serial_rx, mg[0]}, 2'h2)
		ser.rx_active = 1'b0;
		cen = 1'b1;
		ten = 3'h7;
		mbv = 3'h5;
		settle(4);
		`CHK({pr.counter1_zero_input, pr.counter1_phase_b, pr.counter1_phase_a}, 3'h5)
		`CHK({pr.pulse_gen_trigger, pr.serial_rx}, 4'ha)
		cen = 1'b0;
		ten = 3'h1;
		settle(4);
		`CHK({pr.counter1_zero_input, pr.counter1_phase_a, pr.pulse_gen_trigger}, 5'h01)
	endtask : t_ins
	task t_irq;
		{kbe, kbv, jbe, jbv} = 32'hffc5ff3c;
		ien = 16'h0ff0;
		{fsel, asel} = 2'h3;
		settle(4);
		`CHK(irq, 16'h0cc0)
		`CHK({pr.freerun_clock, pr.adc_trigger, ji}, 10'h33c)
		{fsel, asel} = 2'h0;
		settle(2);
		`CHK({pr.freerun_clock, pr.adc_trigger}, 2'h0)
	endtask : t_irq
	task t_gpio;
		{ko, koe, jo, joe} = 32'h5a0fa5f0;
		i2c = 4'h8;
		{lo, loe} = 4'h2;
		settle(4);
		`CHK({kp, kpe, jp, jpe}, 32'h5a0fa5f0)
		`CHK({ki, ji}, 16'hcaac)
		`CHK({lpe, li, pr.i2c_scl_in, pr.i2c_sda_in}, 6'h27)
		`CHK({mi, mg}, 6'h2e)
		{koe, joe, loe} = 18'h0;
		i2c = '0;
	endtask : t_gpio
	initial begin
		settle(10);
		i_reset_n = 1'b1;
		settle(4);
		t_reset();
		t_tx();
		t_clk();
		t_i2c();
		t_ins();
		t_irq();
		t_gpio();
		report_and_stop();
	end
	initial begin
		#25000;
		num_errors++;
		report_and_stop();
	end
endmodule : testbench
